// ### inc/pmx_cfg.svh
`ifndef PMX_CFG_SVH
`define PMX_CFG_SVH

// register byte offsets
`define PMX_OFF_FSEL 8'h00
`define PMX_OFF_IFS 8'h04
`define PMX_OFF_KEY 8'h08
`define PMX_OFF_DATA_A 8'h0c
`define PMX_OFF_DATA_B 8'h10
`define PMX_OFF_DATA_C 8'h14
`define PMX_OFF_DIR_A 8'h18
`define PMX_OFF_DIR_B 8'h1c
`define PMX_OFF_DIR_C 8'h20
`define PMX_OFF_WAKE 8'h24
`define PMX_OFF_BITOP 8'h28
`define PMX_OFF_STATUS 8'h2c

// writable bits, reset values and test-mode key
`define PMX_FSEL_MASK 8'h77
`define PMX_IFS_MASK 8'h7f
`define PMX_SEL_RST 8'h00
`define PMX_KEY_RST 8'h00
`define PMX_PORT_RST 8'hff
`define PMX_WAKE_RST 8'h00
`define PMX_KEY 8'hca

// port_c_pin3 function codes
`define PMX_PC3_ANALOG_CHANNEL_11 3'h1
`define PMX_PC3_CMP3F 3'h2
`define PMX_PC3_CMP4F 3'h3
`define PMX_PC3_RSVD 3'h4

// port_c_pin2 function codes
`define PMX_PC2_LVD 3'h1
`define PMX_PC2_CMP4 3'h2
`define PMX_PC2_CMP2F 3'h3
`define PMX_PC2_SDA 3'h4
`define PMX_PC2_RSVD 3'h5
`define PMX_PC2_COMPARATOR5_NEGATIVE_INPUT 3'h6

// converter channel wired to port_c_pin3
`define PMX_ADC_CH11 4'hb

// bus responses
`define PMX_RESP_OKAY 2'h0
`define PMX_RESP_SLVERR 2'h2

`endif

// ### inc/pmx_pkg.sv
package pmx_pkg;

    typedef struct packed {
        logic [7:0] c;
        logic [7:0] b;
        logic [7:0] a;
    } pmx_port_s;

    typedef enum logic [1:0] {
        PMX_SEL_A,
        PMX_SEL_B,
        PMX_SEL_C,
        PMX_SEL_NONE
    } pmx_port_e;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } pmx_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pmx_axi_rsp_s;

    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [7:0] wdat;
        logic wstb;
        pmx_axi_rsp_s rsp;
    } pmx_axi_st_s;

    typedef struct packed {
        logic [7:0] fsel;
        logic [7:0] input_source_select;
        logic [7:0] key;
        logic [7:0] wake_en;
        pmx_port_s data;
        pmx_port_s dir;
    } pmx_regs_s;

    typedef struct packed {
        pmx_port_s pin_out;
        pmx_port_s pin_oe;
        logic [7:0] pa_prev;
        logic tmr1;
        logic sda;
        logic scl;
        logic analog_channel_11_en;
        logic lvd_en;
        logic comparator5_negative_input_en;
        logic wake;
        logic test_mode;
    } pmx_out_s;

endpackage : pmx_pkg

// ### rtl/pmx_sync.sv
`timescale 1ns/10ps
module pmx_sync #(
    parameter int W = 24
) (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // asynchronous levels in, synchronised out
    input logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // first stage feeds only the second stage
    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule : pmx_sync

// ### rtl/pmx_top.sv
// Summary of operation
// RULE1: pin3 field routes port_c_pin3 functions
// RULE2: pin2 field routes port_c_pin2 functions
// RULE3: unused select bits read zero, reset zero
// RULE4: software keeps input-select bits 6:5 zero
// RULE5: bit 4 picks timer-1 input pin
// RULE6: bits 3:2 pick I2C data pin
// RULE7: bits 1:0 pick I2C clock pin
// RULE8: exact key raises read-back test mode
// RULE9: other key values: latch read, normal pins
// RULE10: key register fully read/write, resets zero
// RULE11: test mode port read returns pin levels
// RULE12: test mode touches only read path
// RULE13: test reads: analog pins read zero
// RULE14: test mode forces selected analog channel
// RULE15: data and direction registers reset high
// RULE16: bit set/clear does whole-port read-modify-write
// RULE17: enabled port A falling edge wakes sleep
// RULE18: software sets direction input for inputs
// RULE19: reserved codes behave as general I/O
`timescale 1ns/10ps
`include "pmx_cfg.svh"
module pmx_top (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // register bus
    input pmx_pkg::pmx_axi_req_s axi_req,
    output pmx_pkg::pmx_axi_rsp_s axi_rsp,
    // pads
    input pmx_pkg::pmx_port_s pin_in,
    output pmx_pkg::pmx_port_s pin_out,
    output pmx_pkg::pmx_port_s pin_oe,
    // peripheral signals toward pins
    input logic comparator3_filtered_output,
    input logic comparator4_filtered_output,
    input logic comparator4_output,
    input logic comparator2_filtered_output,
    input logic i2c_sda_drive_low,
    // converter and power state
    input logic [3:0] adc_channel_select,
    input logic sleep_mode,
    // routed inputs, path switches, test mode and wake-up
    output logic timer1_external_input,
    output logic i2c_data_input,
    output logic i2c_clock_input,
    output logic analog_channel_11_path_en,
    output logic low_voltage_detect_input_path_en,
    output logic comparator5_negative_input_path_en,
    output logic port_readback_test_mode,
    output logic wake_up
);
    pmx_pkg::pmx_port_s pins_s;
    pmx_pkg::pmx_regs_s regs_r;
    pmx_pkg::pmx_regs_s regs_nxt;
    pmx_pkg::pmx_axi_st_s axi_r;
    pmx_pkg::pmx_axi_st_s axi_nxt;
    pmx_pkg::pmx_out_s out_r;
    pmx_pkg::pmx_out_s out_nxt;
    pmx_pkg::pmx_port_e bop_sel;
    logic do_wr;
    logic [7:0] bop_base;
    logic [7:0] rd_byte;
    logic [2:0] fn3;
    logic [2:0] fn2;

    pmx_sync #(
        .W(24)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(pin_in),
        .q(pins_s)
    );

    function automatic logic [7:0] byte_of(input pmx_pkg::pmx_port_e sel,
                                           input pmx_pkg::pmx_port_s p);
        logic [7:0] v;
        v = 8'h00;
        case (sel)
            pmx_pkg::PMX_SEL_A: v = p.a;
            pmx_pkg::PMX_SEL_B: v = p.b;
            pmx_pkg::PMX_SEL_C: v = p.c;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : byte_of

    // port C bits whose selected function is analog
    function automatic logic [7:0] analog_mask(input logic [7:0] fsel);
        logic [7:0] m;
        m = 8'h00;
        m[3] = (fsel[6:4] == `PMX_PC3_ANALOG_CHANNEL_11);
        m[2] = (fsel[2:0] == `PMX_PC2_LVD) || (fsel[2:0] == `PMX_PC2_COMPARATOR5_NEGATIVE_INPUT);
        return m;
    endfunction : analog_mask

    // what a port read instruction sees
    function automatic logic [7:0] port_view(input pmx_pkg::pmx_port_e sel,
                                             input pmx_pkg::pmx_regs_s r,
                                             input pmx_pkg::pmx_port_s p);
        logic [7:0] v;
        v = byte_of(sel, r.data); // RULE9
        if (r.key == `PMX_KEY) begin
            v = byte_of(sel, p); // RULE11
            if (sel == pmx_pkg::PMX_SEL_C) begin
                v = v & ~analog_mask(r.fsel); // RULE13
            end
        end
        return v;
    endfunction : port_view

    function automatic logic reg_hit(input logic [7:0] addr);
        logic hit;
        case ({addr[7:2], 2'b00})
            `PMX_OFF_FSEL, `PMX_OFF_IFS, `PMX_OFF_KEY, `PMX_OFF_WAKE,
            `PMX_OFF_DATA_A, `PMX_OFF_DATA_B, `PMX_OFF_DATA_C,
            `PMX_OFF_DIR_A, `PMX_OFF_DIR_B, `PMX_OFF_DIR_C,
            `PMX_OFF_BITOP, `PMX_OFF_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : reg_hit

    assign do_wr = axi_r.aw_got && axi_r.w_got && !axi_r.rsp.bvalid;

    // bus handshakes; one write and one read outstanding at most
    always_comb begin
        axi_nxt = axi_r;
        if (axi_req.awvalid && axi_r.rsp.awready) begin
            axi_nxt.aw_got = 1'b1;
            axi_nxt.waddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_r.rsp.wready) begin
            axi_nxt.w_got = 1'b1;
            axi_nxt.wdat = axi_req.wdata[7:0];
            axi_nxt.wstb = axi_req.wstrb[0];
        end
        if (axi_r.rsp.bvalid && axi_req.bready) begin
            axi_nxt.rsp.bvalid = 1'b0;
        end
        if (do_wr) begin
            axi_nxt.aw_got = 1'b0;
            axi_nxt.w_got = 1'b0;
            axi_nxt.rsp.bvalid = 1'b1;
            axi_nxt.rsp.bresp = reg_hit(axi_r.waddr) ? `PMX_RESP_OKAY : `PMX_RESP_SLVERR;
        end
        axi_nxt.rsp.awready = !axi_nxt.aw_got && !axi_nxt.rsp.bvalid;
        axi_nxt.rsp.wready = !axi_nxt.w_got && !axi_nxt.rsp.bvalid;
        if (axi_r.rsp.rvalid && axi_req.rready) begin
            axi_nxt.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && axi_r.rsp.arready) begin
            axi_nxt.rsp.rvalid = 1'b1;
            axi_nxt.rsp.rdata = {24'h000000, rd_byte};
            axi_nxt.rsp.rresp = reg_hit(axi_req.araddr) ? `PMX_RESP_OKAY : `PMX_RESP_SLVERR;
        end
        axi_nxt.rsp.arready = !axi_nxt.rsp.rvalid;
    end

    // read mux; reads have no side effects
    always_comb begin
        rd_byte = 8'h00;
        case ({axi_req.araddr[7:2], 2'b00})
            `PMX_OFF_FSEL: rd_byte = regs_r.fsel; // RULE3
            `PMX_OFF_IFS: rd_byte = regs_r.input_source_select;
            `PMX_OFF_KEY: rd_byte = regs_r.key; // RULE10
            `PMX_OFF_DATA_A: rd_byte = port_view(pmx_pkg::PMX_SEL_A, regs_r, pins_s);
            `PMX_OFF_DATA_B: rd_byte = port_view(pmx_pkg::PMX_SEL_B, regs_r, pins_s);
            `PMX_OFF_DATA_C: rd_byte = port_view(pmx_pkg::PMX_SEL_C, regs_r, pins_s);
            `PMX_OFF_DIR_A: rd_byte = regs_r.dir.a;
            `PMX_OFF_DIR_B: rd_byte = regs_r.dir.b;
            `PMX_OFF_DIR_C: rd_byte = regs_r.dir.c;
            `PMX_OFF_WAKE: rd_byte = regs_r.wake_en;
            `PMX_OFF_STATUS: rd_byte = {6'h00, sleep_mode, out_r.test_mode};
            default: rd_byte = 8'h00;
        endcase
    end

    // software state; writes with wstrb[0] low are acknowledged and dropped
    always_comb begin
        regs_nxt = regs_r;
        bop_sel = pmx_pkg::pmx_port_e'(axi_r.wdat[4:3]);
        // in test mode the read half sees pins, so a bit op may rewrite the latch
        if (axi_r.wdat[6]) begin
            bop_base = byte_of(bop_sel, regs_r.dir);
        end else begin
            bop_base = port_view(bop_sel, regs_r, pins_s); // RULE16
        end
        bop_base[axi_r.wdat[2:0]] = axi_r.wdat[5]; // RULE16
        if (do_wr && axi_r.wstb) begin
            case ({axi_r.waddr[7:2], 2'b00})
                `PMX_OFF_FSEL: regs_nxt.fsel = axi_r.wdat & `PMX_FSEL_MASK; // RULE3
                // bits 6:5 stay writable; keeping them zero is software's job
                `PMX_OFF_IFS: regs_nxt.input_source_select = axi_r.wdat & `PMX_IFS_MASK; // RULE4
                `PMX_OFF_KEY: regs_nxt.key = axi_r.wdat; // RULE10
                `PMX_OFF_DATA_A: regs_nxt.data.a = axi_r.wdat;
                `PMX_OFF_DATA_B: regs_nxt.data.b = axi_r.wdat;
                `PMX_OFF_DATA_C: regs_nxt.data.c = axi_r.wdat;
                `PMX_OFF_DIR_A: regs_nxt.dir.a = axi_r.wdat;
                `PMX_OFF_DIR_B: regs_nxt.dir.b = axi_r.wdat;
                `PMX_OFF_DIR_C: regs_nxt.dir.c = axi_r.wdat;
                `PMX_OFF_WAKE: regs_nxt.wake_en = axi_r.wdat;
                `PMX_OFF_BITOP: begin
                    case (bop_sel)
                        pmx_pkg::PMX_SEL_A: begin
                            if (axi_r.wdat[6]) regs_nxt.dir.a = bop_base;
                            else regs_nxt.data.a = bop_base;
                        end
                        pmx_pkg::PMX_SEL_B: begin
                            if (axi_r.wdat[6]) regs_nxt.dir.b = bop_base;
                            else regs_nxt.data.b = bop_base;
                        end
                        pmx_pkg::PMX_SEL_C: begin
                            if (axi_r.wdat[6]) regs_nxt.dir.c = bop_base;
                            else regs_nxt.data.c = bop_base;
                        end
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
    end

    assign fn3 = regs_r.fsel[6:4];
    assign fn2 = regs_r.fsel[2:0];

    // pad drive and routing; test mode never touches pin_out or pin_oe here
    always_comb begin
        out_nxt = out_r;
        out_nxt.pin_out = regs_r.data; // RULE12
        out_nxt.pin_oe = ~regs_r.dir; // RULE15
        case (fn3)
            `PMX_PC3_ANALOG_CHANNEL_11: out_nxt.pin_oe.c[3] = 1'b0; // RULE1
            `PMX_PC3_CMP3F: begin
                out_nxt.pin_out.c[3] = comparator3_filtered_output; // RULE1
                out_nxt.pin_oe.c[3] = 1'b1;
            end
            `PMX_PC3_CMP4F: begin
                out_nxt.pin_out.c[3] = comparator4_filtered_output; // RULE1
                out_nxt.pin_oe.c[3] = 1'b1;
            end
            default: ; // RULE19
        endcase
        case (fn2)
            `PMX_PC2_LVD, `PMX_PC2_COMPARATOR5_NEGATIVE_INPUT: out_nxt.pin_oe.c[2] = 1'b0; // RULE2
            `PMX_PC2_CMP4: begin
                out_nxt.pin_out.c[2] = comparator4_output; // RULE2
                out_nxt.pin_oe.c[2] = 1'b1;
            end
            `PMX_PC2_CMP2F: begin
                out_nxt.pin_out.c[2] = comparator2_filtered_output; // RULE2
                out_nxt.pin_oe.c[2] = 1'b1;
            end
            `PMX_PC2_SDA: begin
                // open drain: only ever pulls low
                out_nxt.pin_out.c[2] = 1'b0; // RULE2
                out_nxt.pin_oe.c[2] = i2c_sda_drive_low;
            end
            default: ; // RULE19
        endcase
        // pin levels reach inputs whatever the direction; RULE18 is on software
        out_nxt.tmr1 = regs_r.input_source_select[4] ? pins_s.c[3] : pins_s.b[1]; // RULE5
        case (regs_r.input_source_select[3:2])
            2'h0: out_nxt.sda = pins_s.a[0]; // RULE6
            2'h1: out_nxt.sda = pins_s.b[1];
            2'h2: out_nxt.sda = pins_s.b[0];
            default: out_nxt.sda = pins_s.c[2];
        endcase
        case (regs_r.input_source_select[1:0])
            2'h0: out_nxt.scl = pins_s.a[2]; // RULE7
            2'h1: out_nxt.scl = pins_s.a[0];
            2'h2: out_nxt.scl = pins_s.b[4];
            default: out_nxt.scl = pins_s.c[1];
        endcase
        out_nxt.test_mode = (regs_r.key == `PMX_KEY); // RULE8 RULE9
        out_nxt.analog_channel_11_en = (fn3 == `PMX_PC3_ANALOG_CHANNEL_11)
            || (out_nxt.test_mode && adc_channel_select == `PMX_ADC_CH11); // RULE14
        out_nxt.lvd_en = (fn2 == `PMX_PC2_LVD);
        out_nxt.comparator5_negative_input_en = (fn2 == `PMX_PC2_COMPARATOR5_NEGATIVE_INPUT);
        out_nxt.pa_prev = pins_s.a;
        out_nxt.wake = sleep_mode && |(regs_r.wake_en & out_r.pa_prev & ~pins_s.a); // RULE17
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            regs_r <= '{fsel: `PMX_SEL_RST, input_source_select: `PMX_SEL_RST, key: `PMX_KEY_RST,
                        wake_en: `PMX_WAKE_RST,
                        data: {3{`PMX_PORT_RST}}, dir: {3{`PMX_PORT_RST}}};
            axi_r <= '0;
            out_r <= '0;
        end else begin
            regs_r <= regs_nxt;
            axi_r <= axi_nxt;
            out_r <= out_nxt;
        end
    end

    assign axi_rsp = axi_r.rsp;
    assign pin_out = out_r.pin_out;
    assign pin_oe = out_r.pin_oe;
    assign timer1_external_input = out_r.tmr1;
    assign i2c_data_input = out_r.sda;
    assign i2c_clock_input = out_r.scl;
    assign analog_channel_11_path_en = out_r.analog_channel_11_en;
    assign low_voltage_detect_input_path_en = out_r.lvd_en;
    assign comparator5_negative_input_path_en = out_r.comparator5_negative_input_en;
    assign port_readback_test_mode = out_r.test_mode;
    assign wake_up = out_r.wake;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_key_enables: assert property ((regs_r.key == `PMX_KEY) |=> port_readback_test_mode) // RULE8
        else $error("key present but test mode low");
    a_other_disables: assert property ((regs_r.key != `PMX_KEY) |=> !port_readback_test_mode) // RULE9
        else $error("test mode high without key");
    a_fsel_unused_zero: assert property (regs_r.fsel[7] == 1'b0 && regs_r.fsel[3] == 1'b0) // RULE3
        else $error("unimplemented select bit set");
    a_tmr1_route: assert property (regs_r.input_source_select[4] |=> timer1_external_input == $past(pins_s.c[3])) // RULE5
        else $error("timer-1 input not from port_c_pin3");
    a_sda_route: assert property ((regs_r.input_source_select[3:2] == 2'h3) |=> i2c_data_input == $past(pins_s.c[2])) // RULE6
        else $error("i2c data input not from port_c_pin2");
    a_scl_route: assert property ((regs_r.input_source_select[1:0] == 2'h0) |=> i2c_clock_input == $past(pins_s.a[2])) // RULE7
        else $error("i2c clock input not from port_a_pin2");
    a_analog_channel_11_forced: assert property ((regs_r.key == `PMX_KEY && adc_channel_select == `PMX_ADC_CH11)
        |=> analog_channel_11_path_en) // RULE14
        else $error("channel 11 path not forced in test mode");
    a_pc3_analog: assert property ((fn3 == `PMX_PC3_ANALOG_CHANNEL_11) |=> !pin_oe.c[3]) // RULE1
        else $error("port_c_pin3 driven while analog");
    a_pc3_reserved: assert property ((fn3 == `PMX_PC3_RSVD) |=> pin_out.c[3] == $past(regs_r.data.c[3])
        && pin_oe.c[3] == !$past(regs_r.dir.c[3])) // RULE19
        else $error("reserved code not general I/O");
    a_wake_edge: assert property ((sleep_mode && regs_r.wake_en[1] && out_r.pa_prev[1] && !pins_s.a[1])
        |=> wake_up) // RULE17
        else $error("falling edge did not wake");
endmodule : pmx_top

// ### sim/pmx_top_tb.sv
`timescale 1ns/10ps
`include "pmx_cfg.svh"
module pmx_top_tb;
    logic aclk;
    logic aresetn;
    pmx_pkg::pmx_axi_req_s req;
    pmx_pkg::pmx_axi_rsp_s rsp;
    pmx_pkg::pmx_port_s pins;
    pmx_pkg::pmx_port_s pin_out;
    pmx_pkg::pmx_port_s pin_oe;
    logic c3f, c4f, c4o, c2f, sda_low, sleep;
    logic [3:0] adc_sel;
    logic tmr1, sda, scl, analog_channel_11_en, lvd_en, comparator5_negative_input_en, test_mode, wake;
    int fail_count;
    int tests_run;
    logic [31:0] rd;
    logic [1:0] resp;
    // one-hot pin index (a=0..7, b=8..15, c=16..23) routed for each select code
    int sda_t[4] = '{0, 9, 8, 18};
    int scl_t[4] = '{2, 0, 12, 17};
    int tc_t[4] = '{9, 19, 9, 19};

    pmx_top dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .pin_in(pins),
        .pin_out(pin_out), .pin_oe(pin_oe), .comparator3_filtered_output(c3f),
        .comparator4_filtered_output(c4f), .comparator4_output(c4o), .comparator2_filtered_output(c2f),
        .i2c_sda_drive_low(sda_low), .adc_channel_select(adc_sel), .sleep_mode(sleep),
        .timer1_external_input(tmr1), .i2c_data_input(sda), .i2c_clock_input(scl),
        .analog_channel_11_path_en(analog_channel_11_en), .low_voltage_detect_input_path_en(lvd_en),
        .comparator5_negative_input_path_en(comparator5_negative_input_en), .port_readback_test_mode(test_mode), .wake_up(wake));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task stop_test;
        $display("fail_count=%0d tests_run=%0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask : chk

    task idle(input int n);
        repeat (n) @(posedge aclk);
    endtask : idle

    task hung(input string nm);
        $display("CHECK FAILED %s expected response seen none", nm);
        fail_count++;
        stop_test();
    endtask : hung

    // each channel is released at the edge that takes it; bready stays up until bvalid
    task axw(input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h000000, d};
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (rsp.awready === 1'b1 && req.awvalid) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1 && req.wvalid) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1 && n < 50);
        if (rsp.bvalid !== 1'b1) hung("write");
        resp = rsp.bresp;
        req.bready <= 1'b0;
    endtask : axw

    task axr(input logic [7:0] a);
        int n;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (rsp.arready === 1'b1 && req.arvalid) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1 && n < 50);
        if (rsp.rvalid !== 1'b1) hung("read");
        rd = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
    endtask : axr

    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        axr(a);
        chk(nm, exp, rd);
    endtask : rd_chk

    function automatic logic route_out(input int k);
        return (k == 0) ? sda : (k == 1) ? scl : tmr1;
    endfunction : route_out

    task t_reset;
        rd_chk("func_sel", `PMX_OFF_FSEL, 32'h0);
        rd_chk("source_sel", `PMX_OFF_IFS, 32'h0);
        rd_chk("key", `PMX_OFF_KEY, 32'h0);
        for (int i = 0; i < 6; i++) rd_chk("port_reg", `PMX_OFF_DATA_A + 8'(4 * i), 32'hff);
        chk("pin_out", 32'h00ffffff, {8'h00, pin_out});
        chk("pin_oe", 32'h0, {8'h00, pin_oe});
        chk("test_mode", 32'h0, {31'h0, test_mode});
        $display("test reset done");
    endtask : t_reset

    task t_access;
        axw(`PMX_OFF_FSEL, 8'hff);
        chk("write_resp", 32'h0, {30'h0, resp});
        rd_chk("func_sel", `PMX_OFF_FSEL, 32'h77);
        axw(`PMX_OFF_IFS, 8'h9f);
        rd_chk("source_sel", `PMX_OFF_IFS, 32'h1f);
        axw(`PMX_OFF_KEY, 8'h35);
        rd_chk("key", `PMX_OFF_KEY, 32'h35);
        axr(8'h40);
        chk("unmapped_resp", 32'h2, {30'h0, resp});
        chk("unmapped_data", 32'h0, rd);
        axw(8'h40, 8'h00);
        chk("unmapped_wresp", 32'h2, {30'h0, resp});
        axw(`PMX_OFF_FSEL, 8'h00);
        axw(`PMX_OFF_IFS, 8'h00);
        $display("test access done");
    endtask : t_access

    task automatic t_key;
        logic [7:0] keys [5] = '{8'hca, 8'hcb, 8'h4a, 8'hca, 8'h00};
        for (int i = 0; i < 5; i++) begin
            axw(`PMX_OFF_KEY, keys[i]);
            idle(1);
            chk("test_mode", {31'h0, keys[i] == 8'hca}, {31'h0, test_mode});
            rd_chk("status", `PMX_OFF_STATUS, {31'h0, keys[i] == 8'hca});
        end
        $display("test key done");
    endtask : t_key

    task t_readback;
        axw(`PMX_OFF_DATA_A, 8'h00);
        pins <= 24'hffffa5;
        idle(4);
        rd_chk("latch_a", `PMX_OFF_DATA_A, 32'h0);
        axw(`PMX_OFF_FSEL, 8'h11);
        axw(`PMX_OFF_KEY, 8'hca);
        rd_chk("pins_a", `PMX_OFF_DATA_A, 32'ha5);
        rd_chk("pins_c", `PMX_OFF_DATA_C, 32'hf3);
        chk("oe_kept", 32'h0, {8'h00, pin_oe});
        chk("out_a_kept", 32'h0, {24'h0, pin_out.a});
        rd_chk("func_kept", `PMX_OFF_FSEL, 32'h11);
        axw(`PMX_OFF_KEY, 8'hcb);
        rd_chk("latch_a", `PMX_OFF_DATA_A, 32'h0);
        axw(`PMX_OFF_FSEL, 8'h00);
        axw(`PMX_OFF_DATA_A, 8'hff);
        $display("test readback done");
    endtask : t_readback

    task t_analog;
        adc_sel <= 4'hb;
        idle(3);
        chk("analog_channel_11_off", 32'h0, {31'h0, analog_channel_11_en});
        axw(`PMX_OFF_KEY, 8'hca);
        idle(1);
        chk("analog_channel_11_forced", 32'h1, {31'h0, analog_channel_11_en});
        adc_sel <= 4'ha;
        idle(3);
        chk("analog_channel_11_other", 32'h0, {31'h0, analog_channel_11_en});
        axw(`PMX_OFF_KEY, 8'h00);
        axw(`PMX_OFF_FSEL, 8'h10);
        idle(1);
        chk("analog_channel_11_sel", 32'h1, {31'h0, analog_channel_11_en});
        axw(`PMX_OFF_FSEL, 8'h01);
        idle(1);
        chk("lvd_en", 32'h1, {31'h0, lvd_en});
        axw(`PMX_OFF_FSEL, 8'h06);
        idle(1);
        chk("comparator5_negative_input_en", 32'h1, {31'h0, comparator5_negative_input_en});
        $display("test analog done");
    endtask : t_analog

    task automatic t_func;
        logic [7:0] sel [4] = '{8'h20, 8'h32, 8'h43, 8'h05};
        logic e3 [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
        logic e2 [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        // comparator levels differ from the latch bit so a general I/O fallback shows
        c3f <= 1'b0;
        c4f <= 1'b0;
        c4o <= 1'b1;
        c2f <= 1'b1;
        axw(`PMX_OFF_DATA_C, 8'h08);
        axw(`PMX_OFF_DIR_C, 8'h00);
        for (int i = 0; i < 4; i++) begin
            axw(`PMX_OFF_FSEL, sel[i]);
            idle(1);
            chk("pin3_out", {31'h0, e3[i]}, {31'h0, pin_out.c[3]});
            chk("pin2_out", {31'h0, e2[i]}, {31'h0, pin_out.c[2]});
        end
        sda_low <= 1'b1;
        axw(`PMX_OFF_FSEL, 8'h04);
        idle(1);
        chk("sda_out", 32'h0, {31'h0, pin_out.c[2]});
        chk("sda_oe", 32'h1, {31'h0, pin_oe.c[2]});
        sda_low <= 1'b0;
        idle(2);
        chk("sda_oe", 32'h0, {31'h0, pin_oe.c[2]});
        axw(`PMX_OFF_FSEL, 8'h00);
        axw(`PMX_OFF_DIR_C, 8'hff);
        axw(`PMX_OFF_DATA_C, 8'hff);
        $display("test function done");
    endtask : t_func

    task t_route;
        int idx;
        logic [1:0] s;
        rd_chk("dir_c_input", `PMX_OFF_DIR_C, 32'hff);
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            axw(`PMX_OFF_IFS, {3'h0, s[0], s, s});
            for (int k = 0; k < 3; k++) begin
                idx = (k == 0) ? sda_t[i] : (k == 1) ? scl_t[i] : tc_t[i];
                pins <= 24'h000001 << idx;
                idle(4);
                chk("route_high", 32'h1, {31'h0, route_out(k)});
                pins <= ~(24'h000001 << idx);
                idle(4);
                chk("route_low", 32'h0, {31'h0, route_out(k)});
            end
        end
        axw(`PMX_OFF_IFS, 8'h00);
        $display("test routing done");
    endtask : t_route

    task t_bitop;
        axw(`PMX_OFF_DATA_B, 8'h5a);
        axw(`PMX_OFF_BITOP, 8'h28);
        rd_chk("data_b", `PMX_OFF_DATA_B, 32'h5b);
        axw(`PMX_OFF_BITOP, 8'h4e);
        rd_chk("dir_b", `PMX_OFF_DIR_B, 32'hbf);
        // in test mode the modify step starts from the pins, not the latch
        pins <= 24'hff0fff;
        idle(4);
        axw(`PMX_OFF_KEY, 8'hca);
        axw(`PMX_OFF_BITOP, 8'h2f);
        axw(`PMX_OFF_KEY, 8'h00);
        rd_chk("data_b_pins", `PMX_OFF_DATA_B, 32'h8f);
        rd_chk("bitop_read", `PMX_OFF_BITOP, 32'h0);
        axw(`PMX_OFF_DIR_B, 8'hff);
        axw(`PMX_OFF_DATA_B, 8'hff);
        $display("test bit op done");
    endtask : t_bitop

    task watch_wake(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (8) begin
            @(posedge aclk);
            if (wake === 1'b1) seen = 1'b1;
        end
        chk("wake", {31'h0, exp}, {31'h0, seen});
    endtask : watch_wake

    task t_wake;
        pins <= 24'hffffff;
        axw(`PMX_OFF_WAKE, 8'h02);
        idle(4);
        // awake: an enabled falling edge must not raise wake_up
        pins <= 24'hfffffd;
        watch_wake(1'b0);
        pins <= 24'hffffff;
        sleep <= 1'b1;
        idle(4);
        pins <= 24'hfffffd;
        watch_wake(1'b1);
        pins <= 24'hfffffc;
        watch_wake(1'b0);
        sleep <= 1'b0;
        $display("test wake done");
    endtask : t_wake

    initial begin
        aresetn = 1'b0;
        req = '0;
        pins = 24'hffffff;
        {c3f, c4f, c4o, c2f, sda_low, sleep} = 6'h00;
        adc_sel = 4'h0;
        fail_count = 0;
        tests_run = 0;
        idle(4);
        aresetn <= 1'b1;
        idle(2);
        t_reset();
        t_access();
        t_key();
        t_readback();
        t_analog();
        t_func();
        t_route();
        t_bitop();
        t_wake();
        stop_test();
    end
endmodule : pmx_top_tb
